// ### rtc_core.sv
// Real-time clock core: host byte bus, timekeeping, user RAM and reset effects
`timescale 1ns/10ps

module rtc_core (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Device pins
    input  wire logic       reset_n_i,
    input  wire logic       user_ram_wipe_n_i,
    input  wire logic       osc_tick_i,
    // Multiplexed host bus
    input  wire logic [7:0] ad_i,
    output logic      [7:0] ad_o,
    output logic            ad_oe_o,
    input  wire logic       as_i,
    input  wire logic       ds_n_i,
    input  wire logic       rw_n_i,
    input  wire logic       ce_n_i,
    // Interrupt request, open drain
    output logic            irq_o,
    output logic            irq_oe_o
);
    import rtc_pkg::*;

    // ==============================
    // State
    typedef struct packed {
        logic [RAM_BYTES-1:0][7:0]  ram;
        logic [TIME_BYTES-1:0][7:0] cnt;
        logic [TIME_BYTES-1:0][7:0] usr;
        logic [6:0]                 reg_a;
        logic [7:0]                 reg_b;
        logic [2:0]                 flag;
        logic [2:0]                 as_s;
        logic [2:0]                 ds_s;
        logic [2:0]                 rw_s;
        logic [2:0]                 ce_s;
        logic [2:0]                 osc_s;
        logic [1:0]                 rstn_s;
        logic [1:0]                 wipe_s;
        logic [2:0][7:0]            ad_s;
        logic [6:0]                 addr;
        logic [7:0]                 rd;
        logic [14:0]                div;
        logic [11:0]                wipe_cnt;
        logic                       uip;
    } state_s;

    function automatic state_s reset_state();
        state_s s;
        s       = '0;
        s.ds_s  = '1;
        s.rw_s  = '1;
        s.ce_s  = '1;
        // Wipe pin idles high; a low start value would begin a false wipe count
        s.wipe_s = '1;
        s.cnt   = TIME_RST;
        s.usr   = TIME_RST;
        s.reg_a = REG_A_RST;
        s.reg_b = REG_B_RST;
        return s;
    endfunction

    localparam state_s ST_RST = reset_state();

    // ==============================
    // Number format helpers
    function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
        return bin ? v : 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]});
    endfunction

    function automatic logic [7:0] from_bin(input logic [7:0] n, input logic bin);
        return bin ? n : {4'(n / 8'd10), 4'(n % 8'd10)};
    endfunction

    // Returns {carry, next}; out-of-range values wrap too
    function automatic logic [8:0] bump(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic bin);
        logic [7:0] n;
        n = to_bin(v, bin);
        if (n >= hi) begin
            return {1'b1, from_bin(lo, bin)};
        end
        return {1'b0, from_bin(8'(n + 8'd1), bin)};
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02:   month_days = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
            8'h04,
            8'h06,
            8'h09,
            8'h0b:   month_days = 8'h1e;
            default: month_days = 8'h1f;
        endcase
    endfunction

    // One-second advance of the counting copy
    function automatic logic [TIME_BYTES-1:0][7:0] advance(
            input logic [TIME_BYTES-1:0][7:0] t, input logic bin, input logic h24);
        logic [8:0] r;
        logic       c;
        logic [7:0] h;
        logic       pm;
        r = bump(t[OFS_SEC[3:0]], 8'h00, SEC_MAX, bin);
        t[OFS_SEC[3:0]] = r[7:0];
        c = r[8];
        if (c) begin
            r = bump(t[OFS_MIN[3:0]], 8'h00, SEC_MAX, bin);
            t[OFS_MIN[3:0]] = r[7:0];
            c = r[8];
        end
        if (c) begin
            if (h24) begin
                r = bump(t[OFS_HOUR[3:0]], 8'h00, HOUR24_MAX, bin);
                t[OFS_HOUR[3:0]] = r[7:0];
                c = r[8];
            end else begin
                pm = t[OFS_HOUR[3:0]][PM_BIT];
                h  = to_bin({1'b0, t[OFS_HOUR[3:0]][6:0]}, bin);
                c  = 1'b0;
                if (h == HOUR12_MAX - 8'd1) begin
                    // 11 to 12 flips the half; 11 PM to 12 AM starts a new day
                    t[OFS_HOUR[3:0]] = {~pm, 7'(from_bin(HOUR12_MAX, bin))};
                    c = pm;
                end else if (h >= HOUR12_MAX) begin
                    t[OFS_HOUR[3:0]] = {pm, 7'(from_bin(8'h01, bin))};
                end else begin
                    t[OFS_HOUR[3:0]] = {pm, 7'(from_bin(8'(h + 8'd1), bin))};
                end
            end
        end
        if (c) begin
            r = bump(t[OFS_WDAY[3:0]], 8'h01, WDAY_MAX, bin);
            t[OFS_WDAY[3:0]] = r[7:0];
            r = bump(t[OFS_MDAY[3:0]], 8'h01,
                     month_days(to_bin(t[OFS_MONTH[3:0]], bin),
                                to_bin(t[OFS_YEAR[3:0]], bin)), bin);
            t[OFS_MDAY[3:0]] = r[7:0];
            c = r[8];
        end
        if (c) begin
            r = bump(t[OFS_MONTH[3:0]], 8'h01, MONTH_MAX, bin);
            t[OFS_MONTH[3:0]] = r[7:0];
            c = r[8];
        end
        if (c) begin
            r = bump(t[OFS_YEAR[3:0]], 8'h00, YEAR_MAX, bin);
            t[OFS_YEAR[3:0]] = r[7:0];
        end
        return t;
    endfunction

    function automatic logic alarm_hit(input logic [7:0] a, input logic [7:0] v);
        return (a[7:6] == DONT_CARE) || (a == v);
    endfunction

    // Edge finders on the two older synchroniser stages
    function automatic logic went_high(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction

    function automatic logic went_low(input logic [2:0] s);
        return s[2] & ~s[1];
    endfunction

    // Address decode shared by the write and read paths
    function automatic logic is_time(input logic [6:0] a);
        return a < OFS_REG_A;
    endfunction

    function automatic logic [6:0] ram_idx(input logic [6:0] a);
        return 7'(a - OFS_RAM);
    endfunction

    // ==============================
    // Next-state logic
    state_s                     q;
    state_s                     d;
    logic                       pin_ok;
    logic                       as_fall;
    logic                       wr_rise;
    logic                       rd_end;
    logic                       tick;
    logic                       sec;
    logic                       set_af;
    logic                       set_uf;
    logic                       clr_c;
    logic                       any_int_flag;
    logic [7:0]                 wd;
    logic [7:0]                 rb;
    logic [TIME_BYTES-1:0][7:0] nxt;

    assign any_int_flag = |(q.flag & q.reg_b[B_PIE:B_UIE]);

    always_comb begin
        d      = q;
        set_af = 1'b0;
        set_uf = 1'b0;
        nxt    = q.cnt;
        wd     = q.ad_s[2];
        rb     = 8'h00;

        // Pins cross two flops; edges are judged on stages two and three
        d.as_s   = {q.as_s[1:0], as_i};
        d.ds_s   = {q.ds_s[1:0], ds_n_i};
        d.rw_s   = {q.rw_s[1:0], rw_n_i};
        d.ce_s   = {q.ce_s[1:0], ce_n_i};
        d.osc_s  = {q.osc_s[1:0], osc_tick_i};
        d.rstn_s = {q.rstn_s[0], reset_n_i};
        d.wipe_s = {q.wipe_s[0], user_ram_wipe_n_i};
        d.ad_s   = {q.ad_s[1:0], ad_i};

        pin_ok  = q.rstn_s[1];
        as_fall = went_low(q.as_s) & pin_ok;
        wr_rise = went_high(q.rw_s) & ~q.ce_s[2] & pin_ok;
        rd_end  = went_high(q.ds_s) & q.rw_s[2] & ~q.ce_s[2] & pin_ok;
        tick    = went_high(q.osc_s);
        sec     = tick && (q.div == 15'(OSC_HZ - 1));
        clr_c   = rd_end && (q.addr == OFS_REG_C);

        // Address comes from one cycle before the strobe edge, while still valid
        // Bit 7 is never latched, so the upper half of the space aliases
        if (as_fall) begin
            d.addr = q.ad_s[2][6:0];
        end

        // Second divider off the oscillator tick
        if (tick) begin
            d.div = sec ? 15'h0000 : 15'(q.div + 15'h0001);
        end
        d.uip = sec;

        // Counting copy always runs; host copy follows unless frozen
        if (sec) begin
            nxt   = advance(q.cnt, q.reg_b[B_DM], q.reg_b[B_H24]);
            d.cnt = nxt;
            if (!q.reg_b[B_SET]) begin
                d.usr = nxt;
            end
            set_uf = 1'b1;
            set_af = alarm_hit(nxt[OFS_ASEC[3:0]], nxt[OFS_SEC[3:0]])
                   & alarm_hit(nxt[OFS_AMIN[3:0]], nxt[OFS_MIN[3:0]])
                   & alarm_hit(nxt[OFS_AHOUR[3:0]], nxt[OFS_HOUR[3:0]]);
        end

        // Host writes; a write beats a same-cycle advance of that byte
        if (wr_rise) begin
            if (is_time(q.addr)) begin
                d.cnt[q.addr[3:0]] = wd;
                d.usr[q.addr[3:0]] = wd;
            end else if (q.addr == OFS_REG_A) begin
                d.reg_a = wd[6:0];
            end else if (q.addr == OFS_REG_B) begin
                d.reg_b = wd;
            end else if (q.addr >= OFS_RAM) begin
                d.ram[ram_idx(q.addr)] = wd;
            end
        end

        // New events win over the read-clear of register C
        d.flag = (q.flag & {3{~clr_c}}) | {1'b0, set_af, set_uf};

        // Wipe counts oscillator ticks so it needs the oscillator running
        if (q.wipe_s[1]) begin
            d.wipe_cnt = 12'h000;
        end else if (tick && q.wipe_cnt != 12'(WIPE_TICKS)) begin
            d.wipe_cnt = 12'(q.wipe_cnt + 12'h001);
        end
        if (!q.wipe_s[1] && q.wipe_cnt == 12'(WIPE_TICKS)) begin
            for (int i = 0; i < RAM_BYTES; i++) begin
                d.ram[i] = RAM_FILL;
            end
        end

        // Pin reset effects
        if (!pin_ok) begin
            d.reg_b[B_PIE]  = 1'b0;
            d.reg_b[B_AIE]  = 1'b0;
            d.reg_b[B_UIE]  = 1'b0;
            d.reg_b[B_SQUARE_OUT_ENABLE] = 1'b0;
            d.flag          = 3'h0;
        end

        // Read data for the latched address
        if (is_time(q.addr)) begin
            rb = q.usr[q.addr[3:0]];
        end else if (q.addr == OFS_REG_A) begin
            rb = {q.uip, q.reg_a};
        end else if (q.addr == OFS_REG_B) begin
            rb = q.reg_b;
        end else if (q.addr == OFS_REG_C) begin
            rb = {any_int_flag, q.flag, 4'h0};
        end else if (q.addr == OFS_REG_D) begin
            rb = REG_D_VAL;
        end else begin
            rb = q.ram[ram_idx(q.addr)];
        end
        d.rd = rb;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // ==============================
    // Outputs
    // Drive only while a selected read strobe stands, never in pin reset
    assign ad_o     = q.rd;
    assign ad_oe_o  = pin_ok & ~q.ce_s[1] & ~q.ds_s[1] & q.rw_s[1];
    assign irq_o    = 1'b0;
    assign irq_oe_o = pin_ok & any_int_flag;
endmodule

// ### rtc_pkg.sv
// Constants for the real-time clock core: address map, bit fields, reset values, timing
package rtc_pkg;

    // ==============================
    // Address map
    localparam int unsigned TIME_BYTES = 10;
    localparam int unsigned CTRL_BYTES = 4;
    localparam int unsigned RAM_BYTES  = 114;
    localparam logic [6:0]  OFS_SEC    = 7'h00;
    localparam logic [6:0]  OFS_ASEC   = 7'h01;
    localparam logic [6:0]  OFS_MIN    = 7'h02;
    localparam logic [6:0]  OFS_AMIN   = 7'h03;
    localparam logic [6:0]  OFS_HOUR   = 7'h04;
    localparam logic [6:0]  OFS_AHOUR  = 7'h05;
    localparam logic [6:0]  OFS_WDAY   = 7'h06;
    localparam logic [6:0]  OFS_MDAY   = 7'h07;
    localparam logic [6:0]  OFS_MONTH  = 7'h08;
    localparam logic [6:0]  OFS_YEAR   = 7'h09;
    localparam logic [6:0]  OFS_REG_A  = 7'h0a;
    localparam logic [6:0]  OFS_REG_B  = 7'h0b;
    localparam logic [6:0]  OFS_REG_C  = 7'h0c;
    localparam logic [6:0]  OFS_REG_D  = 7'h0d;
    localparam logic [6:0]  OFS_RAM    = 7'h0e;

    // ==============================
    // Bit positions
    localparam int unsigned A_UIP  = 7;
    localparam int unsigned B_SET  = 7;
    localparam int unsigned B_PIE  = 6;
    localparam int unsigned B_AIE  = 5;
    localparam int unsigned B_UIE  = 4;
    localparam int unsigned B_SQUARE_OUT_ENABLE = 3;
    localparam int unsigned B_DM   = 2;
    localparam int unsigned B_H24  = 1;
    localparam int unsigned C_ANY_INT_FLAG = 7;
    localparam int unsigned PM_BIT = 7;

    // ==============================
    // Reset and fixed values
    localparam logic [6:0]  REG_A_RST  = 7'h00;
    localparam logic [7:0]  REG_B_RST  = 8'h00;
    localparam logic [7:0]  REG_D_VAL  = 8'h80;
    localparam logic [7:0]  RAM_FILL   = 8'hff;
    localparam logic [1:0]  DONT_CARE  = 2'h3;
    localparam logic [79:0] TIME_RST   = 80'h00_01_01_01_00_00_00_00_00_00;

    // ==============================
    // Counter ranges, binary value
    localparam logic [7:0]  SEC_MAX    = 8'h3b;
    localparam logic [7:0]  HOUR24_MAX = 8'h17;
    localparam logic [7:0]  HOUR12_MAX = 8'h0c;
    localparam logic [7:0]  WDAY_MAX   = 8'h07;
    localparam logic [7:0]  MONTH_MAX  = 8'h0c;
    localparam logic [7:0]  YEAR_MAX   = 8'h63;

    // ==============================
    // Timing
    localparam int unsigned OSC_HZ      = 32768;
    localparam int unsigned RAM_WIPE_MS = 100;
    localparam int unsigned WIPE_TICKS  = (RAM_WIPE_MS * OSC_HZ + 999) / 1000;
endpackage

// ### rtc_core_chk.sv
// Port checker for the real-time clock core
`timescale 1ns/10ps
module rtc_core_chk (
    // Watched ports
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       reset_n_i,
    input wire logic       user_ram_wipe_n_i,
    input wire logic       osc_tick_i,
    input wire logic [7:0] ad_i,
    input wire logic [7:0] ad_o,
    input wire logic       ad_oe_o,
    input wire logic       as_i,
    input wire logic       ds_n_i,
    input wire logic       rw_n_i,
    input wire logic       ce_n_i,
    input wire logic       irq_o,
    input wire logic       irq_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ==============================
    // Steps
    sequence s_pin_rst; !reset_n_i [*3]; endsequence
    sequence s_rd_go; reset_n_i [*4] ##0 ($fell(ds_n_i) && !ce_n_i && rw_n_i); endsequence
    // ==============================
    // Properties
    property p_irq_rel; s_pin_rst |-> !irq_oe_o; endproperty
    property p_bus_ign; s_pin_rst |-> !ad_oe_o; endproperty
    // Enables and flags both gone, so no request until B is rewritten
    property p_int_clr; s_pin_rst ##1 reset_n_i |-> !irq_oe_o [*8]; endproperty
    property p_irq_lvl; irq_o == 1'b0; endproperty
    property p_rd_ans; s_rd_go |-> ##[1:4] ad_oe_o; endproperty
    property p_oe_hold; ad_oe_o && !ds_n_i && !ce_n_i && reset_n_i |=> ad_oe_o; endproperty
    property p_oe_end; $rose(ds_n_i) |-> ##[1:4] !ad_oe_o; endproperty
    property p_no_ds; ds_n_i [*4] |-> !ad_oe_o; endproperty
    property p_desel; ce_n_i [*4] |-> !ad_oe_o; endproperty
    a_irq_rel: assert property (p_irq_rel) else $error("irq in pin reset");
    a_bus_ign: assert property (p_bus_ign) else $error("bus driven in pin reset");
    a_int_clr: assert property (p_int_clr) else $error("irq after pin reset");
    a_irq_lvl: assert property (p_irq_lvl) else $error("irq level not low");
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_oe_hold: assert property (p_oe_hold) else $error("read drive dropped");
    a_oe_end: assert property (p_oe_end) else $error("bus not released");
    a_no_ds: assert property (p_no_ds) else $error("drive without strobe");
    a_desel: assert property (p_desel) else $error("drive while deselected");
endmodule
bind rtc_core rtc_core_chk chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
    .user_ram_wipe_n_i(user_ram_wipe_n_i), .osc_tick_i(osc_tick_i),
    .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .as_i(as_i), .ds_n_i(ds_n_i),
    .rw_n_i(rw_n_i), .ce_n_i(ce_n_i), .irq_o(irq_o), .irq_oe_o(irq_oe_o)
);

// ### rtc_host_model.sv
// Host processor model making multiplexed bus cycles
`timescale 1ns/10ps
module rtc_host_model (
    // Clock
    input  wire logic       clk_i,
    // Device answer
    input  wire logic [7:0] rdata_i,
    input  wire logic       rd_oe_i,
    // Bus drive
    output logic      [7:0] ad_o,
    output logic            as_o,
    output logic            ds_n_o,
    output logic            rw_n_o,
    output logic            ce_n_o
);
    initial begin
        ad_o = 8'h00;
        as_o = 1'b0;
        ds_n_o = 1'b1;
        rw_n_o = 1'b1;
        ce_n_o = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    // Address held well around the strobe fall, synchroniser needs it
    task automatic adr(input logic [7:0] a);
        step(1);
        ad_o = a;
        as_o = 1'b1;
        step(4);
        as_o = 1'b0;
        step(4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ce);
        adr(a);
        ad_o = d;
        ce_n_o = ce;
        rw_n_o = 1'b0;
        step(6);
        rw_n_o = 1'b1;
        step(2);
        ce_n_o = 1'b1;
        ad_o = ~d;
        step(2);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        adr(a);
        ad_o = ~a;
        ds_n_o = 1'b0;
        ce_n_o = 1'b0;
        n = 0;
        while (rd_oe_i !== 1'b1 && n < 8) begin
            step(1);
            n++;
        end
        ok = (rd_oe_i === 1'b1);
        d = rdata_i;
        step(3);
        ds_n_o = 1'b1;
        step(2);
        ce_n_o = 1'b1;
        step(3);
    endtask
endmodule

// ### rtc_core_tb_top.sv
// Self-checking bench for the real-time clock core
`timescale 1ns/10ps
module rtc_core_tb_top;
    import rtc_pkg::*;
    logic       sys_clk_i;
    logic       rst_i;
    logic       reset_n_i;
    logic       wipe_n;
    logic       osc;
    logic [7:0] ad_i, ad_o, host_ad;
    logic       ad_oe_o, as_i, ds_n_i, rw_n_i, ce_n_i, irq_o, irq_oe_o;
    logic [7:0] mem [128];
    int         fail_count  = 0;
    int         check_count = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    assign ad_i = (ad_oe_o === 1'b1) ? ad_o : host_ad;
    rtc_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
        .user_ram_wipe_n_i(wipe_n), .osc_tick_i(osc), .ad_i(ad_i), .ad_o(ad_o),
        .ad_oe_o(ad_oe_o), .as_i(as_i), .ds_n_i(ds_n_i), .rw_n_i(rw_n_i),
        .ce_n_i(ce_n_i), .irq_o(irq_o), .irq_oe_o(irq_oe_o));
    rtc_host_model host (.clk_i(sys_clk_i), .rdata_i(ad_o), .rd_oe_i(ad_oe_o),
        .ad_o(host_ad), .as_o(as_i), .ds_n_o(ds_n_i), .rw_n_o(rw_n_i), .ce_n_o(ce_n_i));
    // ==============================
    // Expectations and bus helpers
    function automatic logic [7:0] after_wr(logic [6:0] a, logic [7:0] o, logic [7:0] d);
        if (a == OFS_REG_C || a == OFS_REG_D)
            return o;
        if (a == OFS_REG_A)
            return {o[7], d[6:0]};
        return d;
    endfunction
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Address bit 7 is dropped, so the mirror index uses six..zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ce);
        host.wr(a, d, ce);
        if (!ce && reset_n_i)
            mem[a[6:0]] = after_wr(a[6:0], mem[a[6:0]], d);
    endtask
    task automatic chk(input logic [7:0] a);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        check_count++;
        if (!ok) begin
            $display("BAD %0t no answer at %h", $time, a);
            fail_count++;
            test_done();
        end else if (d !== mem[a[6:0]]) begin
            $display("BAD %0t at %h read %h want %h", $time, a, d, mem[a[6:0]]);
            fail_count++;
        end
    endtask
    // Read while the pin reset is low must stay unanswered
    task automatic chk_off(input logic [7:0] a);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        check_count++;
        if (ok) begin
            $display("BAD %0t answer in pin reset at %h", $time, a);
            fail_count++;
        end
    endtask
    task automatic chk_all();
        for (int i = 0; i < 128; i++)
            chk(8'(i));
    endtask
    // ==============================
    // Main sequence
    initial begin
        logic [7:0] a;
        sys_clk_i = 1'b0;
        rst_i     = 1'b1;
        reset_n_i = 1'b1;
        wipe_n    = 1'b1;
        osc       = 1'b0;
        void'($urandom(32'h8bf3));
        for (int i = 0; i < 128; i++)
            mem[i] = 8'h00;
        for (int i = 0; i < 10; i++)
            mem[i] = TIME_RST[i*8 +: 8];
        mem[OFS_REG_D] = REG_D_VAL;
        repeat (10) @(posedge sys_clk_i);
        #2;
        rst_i = 1'b0;
        host.step(4);
        chk_all();
        wr(8'h0b, 8'h86, 1'b0);
        for (int i = 0; i < 10; i++)
            wr(8'(i), 8'($urandom_range(1, 7)), 1'b0);
        wr(8'h0a, 8'hff, 1'b0);
        wr(8'h0c, 8'hff, 1'b0);
        wr(8'h0d, 8'h00, 1'b0);
        wr(8'h0b, 8'h06, 1'b0);
        wr(8'h0e, 8'h3c, 1'b0);
        wr(8'hff, 8'hc3, 1'b0);
        // Random user bytes, some through the aliased upper half
        repeat (24) begin
            a = 8'(OFS_RAM) + 8'($urandom_range(0, RAM_BYTES - 1));
            wr({1'($urandom), a[6:0]}, 8'($urandom), 1'b0);
        end
        wr(8'h20, ~mem[7'h20], 1'b1);
        chk_all();
        wr(8'h0b, 8'h7e, 1'b0);
        reset_n_i = 1'b0;
        host.step(6);
        wr(8'h30, ~mem[7'h30], 1'b0);
        chk_off(8'h30);
        reset_n_i = 1'b1;
        host.step(4);
        mem[OFS_REG_B] = mem[OFS_REG_B] & 8'h87;
        chk(8'h0b);
        chk(8'h0c);
        chk(8'h30);
        // Wipe held a little past the tick count for margin
        wipe_n = 1'b0;
        repeat (WIPE_TICKS + 30) begin
            osc = 1'b1;
            host.step(4);
            osc = 1'b0;
            host.step(4);
        end
        wipe_n = 1'b1;
        host.step(4);
        for (int i = OFS_RAM; i < 128; i++)
            mem[i] = RAM_FILL;
        chk_all();
        test_done();
    end
endmodule
